//--- include/adc_defs.svh
// Register map, field positions, reset values and timing factors of the converter control
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

`define ADDR_W 8
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_RESULT 8'h08
`define ADDR_INJ_RESULT 8'h0C
`define ADDR_IRQ_STATUS 8'h10
`define ADDR_IRQ_MASK 8'h14
`define ADDR_DIGIN 8'h18

`define CTRL_CHAN 3:0
`define CTRL_MODE 5:4
`define CTRL_START 6
`define CTRL_WAITRD 7
`define CTRL_INJ 8
`define CTRL_INJCHAN 12:9
`define CTRL_CTC 14:13
`define CTRL_STC 16:15
`define CTRL_STOP 17
`define CTRL_WMASK 32'h0001_FEBF
`define CTRL_RST 32'h0000_0000

`define RES_VALUE 9:0
`define RES_CHAN 15:12

`define IRQ_DONE 0
`define IRQ_OVR 1
`define IRQ_INJ 2
`define IRQ_W 3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define HALF_OSC_CLKS 16'h0001
`define CTC_MUL_00 16'h0018
`define CTC_MUL_10 16'h0060
`define CTC_MUL_11 16'h0030
`define CONV_TCC_N 16'h000E
`define CONV_TSC_N 16'h0002
`define CONV_HALF_N 16'h0004

`endif

//--- include/adc_pkg.sv
// Types shared by the converter control modules
package adc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_HOLD = 3'b100
  } seq_state_e;
  typedef enum logic [1:0] {
    MD_SINGLE = 2'b00,
    MD_CONT = 2'b01,
    MD_SCAN = 2'b10,
    MD_SCAN_CONT = 2'b11
  } conv_mode_e;
endpackage

//--- include/bus_if.sv
// Register access strobes between bus slave and register file
`timescale 1ns/1ps
`include "adc_defs.svh"
interface bus_if;
  logic wrEn;
  logic [`ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrOk;
  logic rdEn;
  logic [`ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic rdOk;
  modport slave (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr, input wrOk, rdData, rdOk);
  modport regs (input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr, output wrOk, rdData, rdOk);
endinterface

//--- include/conv_if.sv
// Conversion timer control and status
`timescale 1ns/1ps
interface conv_if;
  logic start;
  logic [1:0] ctc;
  logic [1:0] stc;
  logic sampling;
  logic done;
  modport ctl (output start, ctc, stc, input sampling, done);
  modport timer (input start, ctc, stc, output sampling, done);
endinterface

//--- src/conv_timer.sv
// Conversion and sample period timer
`timescale 1ns/1ps
`include "adc_defs.svh"
module conv_timer (
  input wire logic clk,
  input wire logic rst,
  conv_if.timer tm
);
  logic [15:0] count;
  logic [15:0] sampCnt;
  logic active;
  logic next_active;
  logic [15:0] next_count;
  logic [15:0] next_sampCnt;
  logic next_sampling;
  logic next_done;

  function automatic logic [15:0] tccOf(input logic [1:0] ctc);
    if (ctc == 2'b10) begin
      tccOf = 16'(`CTC_MUL_10 * `HALF_OSC_CLKS);
    end else if (ctc == 2'b11) begin
      tccOf = 16'(`CTC_MUL_11 * `HALF_OSC_CLKS);
    end else begin
      tccOf = 16'(`CTC_MUL_00 * `HALF_OSC_CLKS);
    end
  endfunction

  function automatic logic [15:0] tscOf(input logic [1:0] ctc, input logic [1:0] stc);
    tscOf = 16'(tccOf(ctc) << stc);
  endfunction

  always_comb begin
    next_active = active;
    next_count = count;
    next_sampCnt = sampCnt;
    next_done = 1'b0;
    if (tm.start) begin
      next_active = 1'b1;
      next_count = 16'(`CONV_TCC_N * tccOf(tm.ctc) + `CONV_TSC_N * tscOf(tm.ctc, tm.stc)
                   + `CONV_HALF_N * `HALF_OSC_CLKS);
      next_sampCnt = 16'(`CONV_TSC_N * tscOf(tm.ctc, tm.stc));
    end else if (active) begin
      next_count = count - 16'h0001;
      if (sampCnt != 16'h0000) begin
        next_sampCnt = sampCnt - 16'h0001;
      end
      if (count == 16'h0001) begin
        next_active = 1'b0;
        next_done = 1'b1;
      end
    end
    next_sampling = next_sampCnt != 16'h0000;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active <= 1'b0;
      count <= 16'h0000;
      sampCnt <= 16'h0000;
      tm.sampling <= 1'b0;
      tm.done <= 1'b0;
    end else begin
      active <= next_active;
      count <= next_count;
      sampCnt <= next_sampCnt;
      tm.sampling <= next_sampling;
      tm.done <= next_done;
    end
  end
endmodule // conv_timer

//--- src/axi_lite_slave.sv
// AXI4-Lite slave turning bus transfers into register strobes
`timescale 1ns/1ps
`include "adc_defs.svh"
module axi_lite_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  bus_if.slave regs
);
  logic [`ADDR_W-1:0] awAddrR;
  logic [31:0] wDataR;
  logic [3:0] wStrbR;
  logic next_awready;
  logic next_wready;
  logic [`ADDR_W-1:0] next_awAddrR;
  logic [31:0] next_wDataR;
  logic [3:0] next_wStrbR;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  // Write fires once address and data are both held and no response is pending
  assign regs.wrEn = !awready && !wready && !bvalid;
  assign regs.wrAddr = awAddrR;
  assign regs.wrData = wDataR;
  assign regs.wrStrb = wStrbR;
  assign regs.rdEn = arvalid && arready;
  assign regs.rdAddr = araddr;

  always_comb begin
    next_awready = awready;
    next_wready = wready;
    next_awAddrR = awAddrR;
    next_wDataR = wDataR;
    next_wStrbR = wStrbR;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready) begin
      next_awready = 1'b0;
      next_awAddrR = awaddr;
    end
    if (wvalid && wready) begin
      next_wready = 1'b0;
      next_wDataR = wdata;
      next_wStrbR = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (regs.wrEn) begin
      next_bvalid = 1'b1;
      next_bresp = regs.wrOk ? `RESP_OKAY : `RESP_SLVERR;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (regs.rdEn) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = regs.rdData;
      next_rresp = regs.rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awAddrR <= '0;
      wDataR <= 32'h0000_0000;
      wStrbR <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      awready <= next_awready;
      wready <= next_wready;
      awAddrR <= next_awAddrR;
      wDataR <= next_wDataR;
      wStrbR <= next_wStrbR;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule // axi_lite_slave

//--- src/adc_sequencer_control.sv
// Sequencer, register file and interrupt logic of the 16-channel converter
// Contract
// - Results are 10 bits from one of 16 channels; unused channels read as digital inputs.
// - A result finished before the last was read raises overrun, or waits when hold is on.
// - Single-channel single mode converts the chosen channel once, stores it and stops.
// - Single-channel continuous mode converts the chosen channel over and over.
// - Scan single mode converts each selected channel once, storing after each conversion.
// - Scan continuous mode cycles through the selected channels without end.
// - Every stored result is signalled for software or the event transfer unit.
// - With wait-for-read on, a new result waits in a buffer and converting pauses until read.
// - In continuous modes an injected channel is converted into the injection result.
// - Conversion clock select 00, 10, 11 gives 24, 96, 48 half-oscillator periods.
// - Sample clock select 00 to 11 gives 1, 2, 4, 8 conversion clocks.
// - A conversion takes 14 conversion clocks, 2 sample clocks and 4 half periods.
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_sequencer_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [9:0] convData,
  input wire logic [15:0] digitalIn,
  output logic [3:0] chanSel,
  output logic sampleHold,
  output logic resultEvent,
  output logic irq
);
  bus_if bus ();
  conv_if cv ();

  adc_pkg::seq_state_e state;
  adc_pkg::seq_state_e next_state;
  logic [31:0] ctrlReg;
  logic [31:0] next_ctrlReg;
  adc_pkg::conv_mode_e mode;
  adc_pkg::conv_mode_e next_mode;
  logic [3:0] topChan;
  logic [3:0] next_topChan;
  logic [3:0] curChan;
  logic [3:0] next_curChan;
  logic running;
  logic next_running;
  logic [9:0] result;
  logic [9:0] next_result;
  logic [3:0] resultChan;
  logic [3:0] next_resultChan;
  logic pending;
  logic next_pending;
  logic [9:0] holdBuf;
  logic [9:0] next_holdBuf;
  logic [3:0] holdChan;
  logic [3:0] next_holdChan;
  logic holdGo;
  logic next_holdGo;
  logic [9:0] injResult;
  logic [9:0] next_injResult;
  logic [3:0] injChanR;
  logic [3:0] next_injChanR;
  logic injPending;
  logic next_injPending;
  logic injActive;
  logic next_injActive;
  logic startPulse;
  logic next_startPulse;
  logic [3:0] next_chanSel;
  logic next_resultEvent;
  logic [`IRQ_W-1:0] irqStat;
  logic [`IRQ_W-1:0] next_irqStat;
  logic [`IRQ_W-1:0] irqMask;
  logic [`IRQ_W-1:0] next_irqMask;
  logic next_irq;
  logic [31:0] wdCtrl;
  logic wrCtrl;
  logic rdResult;
  logic adv;
  logic cont;
  logic [3:0] advChan;
  logic [4:0] nx;
  logic [`IRQ_W-1:0] events;

  axi_lite_slave u_bus (
    .clk(clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regs(bus.slave)
  );

  conv_timer u_tmr (
    .clk(clk),
    .rst(rst),
    .tm(cv.timer)
  );

  assign cv.start = startPulse;
  assign cv.ctc = ctrlReg[`CTRL_CTC];
  assign cv.stc = ctrlReg[`CTRL_STC];

  // Byte lane merge of a write into a stored word
  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    mergeStrb = r;
  endfunction

  // Next channel and continue flag of a sequence after one conversion
  function automatic logic [4:0] seqNext(input adc_pkg::conv_mode_e m, input logic [3:0] cur,
                                         input logic [3:0] top);
    case (m)
      adc_pkg::MD_SINGLE: seqNext = {1'b0, cur};
      adc_pkg::MD_CONT: seqNext = {1'b1, cur};
      adc_pkg::MD_SCAN: seqNext = (cur == 4'h0) ? {1'b0, top} : {1'b1, cur - 4'h1};
      default: seqNext = (cur == 4'h0) ? {1'b1, top} : {1'b1, cur - 4'h1};
    endcase
  endfunction

  // Channels taken by the running sequence
  function automatic logic [15:0] chanMask(input adc_pkg::conv_mode_e m, input logic [3:0] top);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if ((m[1] && i <= int'(top)) || (!m[1] && i == int'(top))) begin
        r[i] = 1'b1;
      end
    end
    chanMask = r;
  endfunction

  assign wrCtrl = bus.wrEn && bus.wrAddr == `ADDR_CTRL;
  assign wdCtrl = mergeStrb(ctrlReg, bus.wrData, bus.wrStrb);
  assign rdResult = bus.rdEn && bus.rdAddr == `ADDR_RESULT;

  // Register read mux and address decode
  always_comb begin
    bus.rdData = 32'h0000_0000;
    bus.rdOk = 1'b1;
    if (bus.rdAddr == `ADDR_CTRL) begin
      bus.rdData = ctrlReg;
    end else if (bus.rdAddr == `ADDR_STATUS) begin
      bus.rdData = {28'h000_0000, state == adc_pkg::ST_HOLD, injActive | injPending, pending,
                    state != adc_pkg::ST_IDLE};
    end else if (bus.rdAddr == `ADDR_RESULT) begin
      bus.rdData[`RES_VALUE] = result;
      bus.rdData[`RES_CHAN] = resultChan;
    end else if (bus.rdAddr == `ADDR_INJ_RESULT) begin
      bus.rdData[`RES_VALUE] = injResult;
      bus.rdData[`RES_CHAN] = injChanR;
    end else if (bus.rdAddr == `ADDR_IRQ_STATUS) begin
      bus.rdData[`IRQ_W-1:0] = irqStat;
    end else if (bus.rdAddr == `ADDR_IRQ_MASK) begin
      bus.rdData[`IRQ_W-1:0] = irqMask;
    end else if (bus.rdAddr == `ADDR_DIGIN) begin
      bus.rdData[15:0] = digitalIn & ~(running ? chanMask(mode, topChan) : 16'h0000);
    end else begin
      bus.rdOk = 1'b0;
    end
  end

  always_comb begin
    bus.wrOk = 1'b1;
    if (bus.wrAddr == `ADDR_CTRL) begin
      bus.wrOk = 1'b1;
    end else if (bus.wrAddr == `ADDR_IRQ_STATUS || bus.wrAddr == `ADDR_IRQ_MASK) begin
      bus.wrOk = 1'b1;
    end else if (bus.wrAddr == `ADDR_STATUS || bus.wrAddr == `ADDR_RESULT) begin
      bus.wrOk = 1'b1;
    end else if (bus.wrAddr == `ADDR_INJ_RESULT || bus.wrAddr == `ADDR_DIGIN) begin
      bus.wrOk = 1'b1;
    end else begin
      bus.wrOk = 1'b0;
    end
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_ctrlReg = ctrlReg;
    next_mode = mode;
    next_topChan = topChan;
    next_curChan = curChan;
    next_running = running;
    next_result = result;
    next_resultChan = resultChan;
    next_pending = pending;
    next_holdBuf = holdBuf;
    next_holdChan = holdChan;
    next_holdGo = holdGo;
    next_injResult = injResult;
    next_injChanR = injChanR;
    next_injPending = injPending;
    next_injActive = injActive;
    next_startPulse = 1'b0;
    next_chanSel = chanSel;
    next_resultEvent = 1'b0;
    events = '0;
    adv = 1'b0;
    cont = 1'b0;
    advChan = curChan;
    nx = seqNext(mode, curChan, topChan);
    if (wrCtrl) begin
      next_ctrlReg = wdCtrl & `CTRL_WMASK;
      if (wdCtrl[`CTRL_STOP]) begin
        next_running = 1'b0;
      end
      if (wdCtrl[`CTRL_INJ] && running && mode[0]) begin
        next_injPending = 1'b1;
      end
    end
    if (rdResult) begin
      next_pending = 1'b0;
    end
    case (state)
      adc_pkg::ST_IDLE: begin
        if (wrCtrl && wdCtrl[`CTRL_START]) begin
          next_mode = adc_pkg::conv_mode_e'(wdCtrl[`CTRL_MODE]);
          next_topChan = wdCtrl[`CTRL_CHAN];
          next_curChan = wdCtrl[`CTRL_CHAN];
          next_chanSel = wdCtrl[`CTRL_CHAN];
          next_running = 1'b1;
          next_startPulse = 1'b1;
          next_state = adc_pkg::ST_CONV;
        end
      end
      adc_pkg::ST_CONV: begin
        if (cv.done && injActive) begin
          next_injResult = convData;
          next_injChanR = chanSel;
          next_injActive = 1'b0;
          events[`IRQ_INJ] = 1'b1;
          adv = 1'b1;
          cont = 1'b1;
        end else if (cv.done) begin
          if (pending && !rdResult && ctrlReg[`CTRL_WAITRD]) begin
            next_holdBuf = convData;
            next_holdChan = chanSel;
            next_curChan = nx[3:0];
            next_holdGo = nx[4];
            next_state = adc_pkg::ST_HOLD;
          end else begin
            next_result = convData;
            next_resultChan = chanSel;
            next_pending = 1'b1;
            next_resultEvent = 1'b1;
            events[`IRQ_DONE] = 1'b1;
            events[`IRQ_OVR] = pending && !rdResult;
            adv = 1'b1;
            cont = nx[4];
            advChan = nx[3:0];
          end
        end
      end
      adc_pkg::ST_HOLD: begin
        if (rdResult) begin
          next_result = holdBuf;
          next_resultChan = holdChan;
          next_pending = 1'b1;
          next_resultEvent = 1'b1;
          events[`IRQ_DONE] = 1'b1;
          adv = 1'b1;
          cont = holdGo;
        end
      end
      default: begin
        next_state = adc_pkg::ST_IDLE;
      end
    endcase
    if (adv) begin
      if (cont && next_running) begin
        next_curChan = advChan;
        next_startPulse = 1'b1;
        next_state = adc_pkg::ST_CONV;
        if (next_injPending) begin
          next_chanSel = ctrlReg[`CTRL_INJCHAN];
          next_injActive = 1'b1;
          next_injPending = 1'b0;
        end else begin
          next_chanSel = advChan;
        end
      end else begin
        next_state = adc_pkg::ST_IDLE;
        next_running = 1'b0;
        next_injPending = 1'b0;
      end
    end
    next_irqMask = irqMask;
    next_irqStat = irqStat;
    if (bus.wrEn && bus.wrAddr == `ADDR_IRQ_MASK && bus.wrStrb[0]) begin
      next_irqMask = bus.wrData[`IRQ_W-1:0];
    end
    if (bus.wrEn && bus.wrAddr == `ADDR_IRQ_STATUS && bus.wrStrb[0]) begin
      next_irqStat = irqStat & ~bus.wrData[`IRQ_W-1:0];
    end
    next_irqStat = next_irqStat | events;
    next_irq = |(next_irqStat & next_irqMask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= adc_pkg::ST_IDLE;
      ctrlReg <= `CTRL_RST;
      mode <= adc_pkg::MD_SINGLE;
      topChan <= 4'h0;
      curChan <= 4'h0;
      running <= 1'b0;
      result <= 10'h000;
      resultChan <= 4'h0;
      pending <= 1'b0;
      holdBuf <= 10'h000;
      holdChan <= 4'h0;
      holdGo <= 1'b0;
      injResult <= 10'h000;
      injChanR <= 4'h0;
      injPending <= 1'b0;
      injActive <= 1'b0;
      startPulse <= 1'b0;
      chanSel <= 4'h0;
      resultEvent <= 1'b0;
      irqStat <= '0;
      irqMask <= '0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      ctrlReg <= next_ctrlReg;
      mode <= next_mode;
      topChan <= next_topChan;
      curChan <= next_curChan;
      running <= next_running;
      result <= next_result;
      resultChan <= next_resultChan;
      pending <= next_pending;
      holdBuf <= next_holdBuf;
      holdChan <= next_holdChan;
      holdGo <= next_holdGo;
      injResult <= next_injResult;
      injChanR <= next_injChanR;
      injPending <= next_injPending;
      injActive <= next_injActive;
      startPulse <= next_startPulse;
      chanSel <= next_chanSel;
      resultEvent <= next_resultEvent;
      irqStat <= next_irqStat;
      irqMask <= next_irqMask;
      irq <= next_irq;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sampleHold <= 1'b0;
    end else begin
      sampleHold <= cv.sampling;
    end
  end
endmodule // adc_sequencer_control

//--- sim/adc_sequencer_control_assertions.sv
// Port-level checks of the converter control
`timescale 1ns/1ps
module adc_sequencer_control_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [3:0] chanSel,
  input wire logic sampleHold,
  input wire logic resultEvent
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [11:0] holdLen;
  logic [11:0] next_holdLen;
  always_comb next_holdLen = sampleHold ? holdLen + 12'h001 : 12'h000;
  always_ff @(posedge clk) holdLen <= rst ? 12'h000 : next_holdLen;
  property p_evt_pulse; resultEvent |=> !resultEvent; endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event too long");
  property p_chan_steady; sampleHold [*2] |-> $stable(chanSel); endproperty
  a_chan_steady: assert property (p_chan_steady) else $error("channel moved");
  property p_sample_len;
    $fell(sampleHold) |-> holdLen == 12'h030 || holdLen == 12'h060 || holdLen == 12'h0C0
      || holdLen == 12'h180 || holdLen == 12'h300 || holdLen == 12'h600;
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("bad sample length");
  property p_store_after; resultEvent |-> !sampleHold; endproperty
  a_store_after: assert property (p_store_after) else $error("store in sample");
  property p_rd_answer; arvalid && arready |=> rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("late read data");
  property p_wr_answer; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("late write reply");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write reply dropped");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule // adc_sequencer_control_assertions
bind adc_sequencer_control adc_sequencer_control_assertions i_adc_sequencer_control_assertions (.*);

//--- sim/adc_mux_model.sv
// Analog multiplexer model: converter value names the selected channel
`timescale 1ns/1ps
module adc_mux_model (
  input wire logic [3:0] chanSel,
  output logic [9:0] convData,
  output logic [15:0] digitalIn
);
  assign convData = {chanSel, ~chanSel, 2'h2};
  assign digitalIn = 16'hA5C3;
endmodule // adc_mux_model

//--- sim/adc_sequencer_control_test.sv
// Self-checking testbench of the converter control
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_sequencer_control_test;
  logic clk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid;
  logic sampleHold, resultEvent, irq;
  logic [`ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0] wstrb = 4'hF, chanSel;
  logic [1:0] bresp, rresp, rsp;
  logic [9:0] convData;
  logic [15:0] digitalIn;
  int err_count = 0, samples_checked = 0;
  adc_sequencer_control i_adc_sequencer_control (.*);
  adc_mux_model i_adc_mux_model (.chanSel, .convData, .digitalIn);
  always #25 clk = ~clk;
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    err_count++;
    $display("wrong value %s expected reply seen timeout", what);
    report_and_stop;
  endtask
  function automatic logic [31:0] res(input logic [3:0] ch);
    return {16'h0000, ch, 2'h0, ch, ~ch, 2'h2};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (bvalid === 1'h1 && bready === 1'h1) break;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      bready <= (n >= 3);
    end
    bready <= 1'h0;
    rsp = bresp;
    if (n == 50) hang("write");
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (rvalid === 1'h1 && rready === 1'h1) break;
      if (arready === 1'h1) arvalid <= 1'h0;
      rready <= (n >= 2);
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (n == 50) hang("read");
  endtask
  task automatic wait_evt(input int lim, output int k);
    for (k = 1; k <= lim; k++) begin
      @(posedge clk);
      if (resultEvent === 1'h1) break;
    end
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
  endtask
  task automatic t_reset_regs;
    rd_reg(`ADDR_CTRL, rd, rsp);
    chk("ctrl", rd, `CTRL_RST);
    rd_reg(`ADDR_IRQ_MASK, rd, rsp);
    chk("mask", rd, 32'h0000_0000);
    rd_reg(`ADDR_DIGIN, rd, rsp);
    chk("digital in", rd, 32'h0000_A5C3);
    rd_reg(8'h1C, rd, rsp);
    chk("unmapped", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(8'h1C, 32'h0000_0000);
    chk("unmapped write", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
  endtask
  task automatic t_single;
    int k;
    wr(`ADDR_IRQ_MASK, 32'h0000_0001);
    chk("write reply", {30'h0, rsp}, 32'h0000_0000);
    wr(`ADDR_CTRL, 32'h0000_0045);
    wait_evt(1000, k);
    if (k > 1000) hang("single");
    repeat (2) @(posedge clk);
    chk("irq set", irq, 32'h0000_0001);
    rd_reg(`ADDR_RESULT, rd, rsp);
    chk("result", rd, res(4'h5));
    rd_reg(`ADDR_STATUS, rd, rsp);
    chk("status", rd, 32'h0000_0000);
    wait_evt(1000, k);
    chk("stopped", k, 1001);
    wr(`ADDR_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq clear", irq, 32'h0000_0000);
  endtask
  task automatic t_clocks;
    logic [1:0] ctc [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
    logic [1:0] stc [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int len [4] = '{48, 384, 768, 192};
    int k;
    for (int i = 0; i < 4; i++) begin
      do_reset;
      wr(`ADDR_CTRL, {15'h0, stc[i], ctc[i], 13'h0041});
      for (k = 0; k < 3000 && sampleHold !== 1'h1; k++) @(posedge clk);
      for (k = 0; k < 3000 && sampleHold === 1'h1; k++) @(posedge clk);
      chk("sample length", k, len[i]);
    end
  endtask
  task automatic t_cont;
    int k;
    do_reset;
    wr(`ADDR_IRQ_MASK, 32'h0000_0004);
    wr(`ADDR_CTRL, 32'h0000_0053);
    wait_evt(1000, k);
    wait_evt(1000, k);
    chk("period", k, 390);
    rd_reg(`ADDR_IRQ_STATUS, rd, rsp);
    chk("overrun", rd, 32'h0000_0003);
    wr(`ADDR_CTRL, 32'h0000_1313);
    for (k = 0; k < 2000 && irq !== 1'h1; k++) @(posedge clk);
    if (k == 2000) hang("inject");
    rd_reg(`ADDR_INJ_RESULT, rd, rsp);
    chk("injected", rd, res(4'h9));
    wait_evt(1000, k);
    rd_reg(`ADDR_RESULT, rd, rsp);
    chk("resumed", rd, res(4'h3));
  endtask
  task automatic t_scan(input logic [31:0] ctl, input int n);
    int k;
    do_reset;
    wr(`ADDR_CTRL, ctl);
    for (int j = 0; j < n; j++) begin
      wait_evt(1000, k);
      rd_reg(`ADDR_RESULT, rd, rsp);
      chk("scan result", rd, res(4'(2 - j % 3)));
      if (j == 0) begin
        rd_reg(`ADDR_DIGIN, rd, rsp);
        chk("digital in busy", rd, 32'h0000_A5C0);
      end
    end
    wait_evt(1000, k);
    chk("scan goes on", {31'h0, k <= 1000}, {31'h0, ctl[4]});
    wr(`ADDR_CTRL, 32'h0002_0000);
    wait_evt(1000, k);
    wait_evt(1000, k);
    chk("stop", k, 1001);
  endtask
  task automatic t_hold;
    int k;
    do_reset;
    wr(`ADDR_CTRL, 32'h0000_00D7);
    wait_evt(1000, k);
    wait_evt(900, k);
    chk("held", k, 901);
    rd_reg(`ADDR_STATUS, rd, rsp);
    chk("hold flag", rd & 32'h0000_0008, 32'h0000_0008);
    rd_reg(`ADDR_RESULT, rd, rsp);
    chk("kept", rd, res(4'h7));
    rd_reg(`ADDR_STATUS, rd, rsp);
    chk("released", rd & 32'h0000_000A, 32'h0000_0002);
    rd_reg(`ADDR_RESULT, rd, rsp);
    chk("buffered", rd, res(4'h7));
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    t_reset_regs;
    t_single;
    t_clocks;
    t_cont;
    t_scan(32'h0000_0062, 3);
    t_scan(32'h0000_0072, 4);
    t_hold;
    report_and_stop;
  end
endmodule // adc_sequencer_control_test
